/* File: logic/ees_top.v */
// How it works
// - Feedback serial word decoded from Gray or plain binary, per control bit.
// - Master sends serial word in mode 2; slave reads it with gearing mode 5.
// - One registered emulation output may feed up to sixteen slave inputs.
// - Incremental mode gives A and B in quadrature, zero pulse only at A=B=1.
// - Pulses per turn programmable; range depends on resolver or encoder feedback.
// - With safety card fitted only power-of-two resolutions up to 4096 accepted.
// - Zero pulse position shifted within the turn by a stored offset.
// - By default emulated position counts up as shaft position increases.
// - Serial word goes out on the emulation port only in mode 2.
// - A serial frame carries at most 32 data bits.
// - Frame starts with revolution count, 12 to 16 bits, MSB first.
// - Then a fixed 16-bit single-turn position, MSB first.
// - Emulated serial word sent in Gray or plain binary, per control bit.
// - Clock deglitch count matched to the evaluator clock frequency.
// - Clock idle for 3 us or 13 us ends a transfer and returns to idle.
// - Port signal rate never above 1.5 MHz.
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ees_regs.vh"
module ees_top #(
  parameter RES_W = 20
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire [7:0]       paddr,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [31:0]      pwdata,
  output wire [31:0]      prdata,
  output wire             pready,
  output wire             pslverr,
  input  wire [15:0]      shaft_turn,
  input  wire [15:0]      shaft_rev,
  input  wire             emu_clk_pin,
  output wire             emu_data,
  output wire             quad_a,
  output wire             quad_b,
  output wire             zero_pulse,
  output wire             fb_clk,
  input  wire             fb_data_pin
);
  localparam [7:0] TOUT_SHORT = `EES_TOUT_SHORT_CYC;
  localparam [7:0] TOUT_LONG  = `EES_TOUT_LONG_CYC;
  localparam [3:0] EDGE_CYC   = `EES_EDGE_CYC;
  localparam [7:0] HALF_MIN   = `EES_HALF_MIN_CYC;
  localparam [1:0] E_IDLE     = 2'h0;
  localparam [1:0] E_SHIFT    = 2'h1;
  localparam [1:0] E_TAIL     = 2'h2;
  localparam [1:0] R_GAP      = 2'h0;
  localparam [1:0] R_LOW      = 2'h1;
  localparam [1:0] R_HIGH     = 2'h2;

  // ****************************************
  // Helper functions
  // ****************************************
  function [4:0] rev_clamp;
    input [4:0] v;
    begin
      rev_clamp = (v < `EES_REVB_MIN) ? `EES_REVB_MIN : ((v > `EES_REVB_MAX) ? `EES_REVB_MAX : v);
    end
  endfunction

  function [31:0] gray2bin;
    input [31:0] g;
    integer i;
    begin
      gray2bin = g;
      for (i = 30; i >= 0; i = i - 1)
        gray2bin[i] = gray2bin[i+1] ^ g[i];
    end
  endfunction

  function res_ok;
    input [RES_W-1:0] r;
    input [5:0]       fbt;
    input             safe;
    reg               pow2;
    reg               in_range;
    begin
      pow2 = (r != {RES_W{1'b0}}) && ((r & (r - 1'b1)) == {RES_W{1'b0}});
      in_range = (fbt == `EES_FBT_RESOLVER) ? ((r >= `EES_RES_RSLV_MIN) && (r <= `EES_RES_RSLV_MAX)) :
                                              ((r >= `EES_RES_ENC_MIN) && (r <= `EES_RES_ENC_MAX));
      res_ok = in_range && (!safe || (pow2 && r <= `EES_RES_SAFE_MAX));
    end
  endfunction

  // ****************************************
  // Registers and fields
  // ****************************************
  reg  [31:0]      ctrl_reg;
  reg  [RES_W-1:0] res_reg;
  reg  [15:0]      zoff_reg;
  reg  [11:0]      clk_reg;
  reg              rej_reg;
  reg  [31:0]      fbpos_reg;
  reg  [31:0]      prdata_reg;
  reg  [31:0]      rd_next;
  wire [2:0]       emu_mode  = ctrl_reg[`EES_CTRL_MODE_LSB +: 3];
  wire [2:0]       gear_mode = ctrl_reg[`EES_CTRL_GEAR_LSB +: 3];
  wire [4:0]       rev_bits  = rev_clamp(ctrl_reg[`EES_CTRL_REVB_LSB +: 5]);
  wire [5:0]       fb_type   = ctrl_reg[`EES_CTRL_FBT_LSB +: 6];
  wire [7:0]       tout_cyc  = ctrl_reg[`EES_CTRL_TOUT_SEL] ? TOUT_LONG : TOUT_SHORT;
  wire [7:0]       half_cyc  = (clk_reg[7:0] < HALF_MIN) ? HALF_MIN : clk_reg[7:0];
  wire [3:0]       match_cyc = clk_reg[`EES_CLK_MATCH_LSB +: 4];
  wire [5:0]       nbits     = {1'b0, rev_bits} + `EES_TURN_BITS;

  // ****************************************
  // APB slave
  // ****************************************
  wire setup   = psel & ~penable;
  wire access  = psel & penable;
  wire addr_ok = (paddr == `EES_ADDR_CTRL) || (paddr == `EES_ADDR_RES) ||
                 (paddr == `EES_ADDR_ZOFF) || (paddr == `EES_ADDR_CLK) ||
                 (paddr == `EES_ADDR_STAT) || (paddr == `EES_ADDR_FBPOS);
  wire wr      = access & pwrite & addr_ok;
  wire res_bad = wr && (paddr == `EES_ADDR_RES) &&
                 !res_ok(pwdata[RES_W-1:0], fb_type, ctrl_reg[`EES_CTRL_SAFETY]);
  wire emu_busy;
  wire rdr_busy;

  // Zero wait states; unmapped addresses answer with an error
  assign pready  = 1'b1;
  assign pslverr = access & ~addr_ok;
  assign prdata  = prdata_reg;

  // Read mux, sampled during the setup cycle
  always @* begin
    rd_next = 32'h00000000;
    case (paddr)
      `EES_ADDR_CTRL:  rd_next = ctrl_reg;
      `EES_ADDR_RES:   rd_next = {{(32-RES_W){1'b0}}, res_reg};
      `EES_ADDR_ZOFF:  rd_next = {16'h0000, zoff_reg};
      `EES_ADDR_CLK:   rd_next = {20'h00000, clk_reg};
      `EES_ADDR_STAT:  rd_next = {29'h00000000, rdr_busy, rej_reg, emu_busy};
      `EES_ADDR_FBPOS: rd_next = fbpos_reg;
      default:         rd_next = 32'h00000000;
    endcase
  end

  // Register writes; a refused resolution keeps the old value and sets a flag
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg   <= `EES_CTRL_RESET;
      res_reg    <= `EES_RES_RESET;
      zoff_reg   <= `EES_ZOFF_RESET;
      clk_reg    <= `EES_CLK_RESET;
      rej_reg    <= 1'b0;
      prdata_reg <= 32'h00000000;
    end else begin
      if (setup && !pwrite)
        prdata_reg <= rd_next;
      if (wr && paddr == `EES_ADDR_CTRL)
        ctrl_reg <= pwdata;
      if (wr && paddr == `EES_ADDR_RES && !res_bad)
        res_reg <= pwdata[RES_W-1:0];
      if (wr && paddr == `EES_ADDR_ZOFF)
        zoff_reg <= pwdata[15:0];
      if (wr && paddr == `EES_ADDR_CLK)
        clk_reg <= pwdata[11:0];
      // Set wins over the write-one clear
      if (res_bad)
        rej_reg <= 1'b1;
      else if (wr && paddr == `EES_ADDR_STAT && pwdata[1])
        rej_reg <= 1'b0;
    end
  end

  // ****************************************
  // Position scaling
  // ****************************************
  wire [31:0]         pos_raw  = {shaft_rev, shaft_turn};
  wire [31:0]         pos_dir  = ctrl_reg[`EES_CTRL_DIR_INV] ? (32'h00000000 - pos_raw) : pos_raw;
  wire [31+RES_W:0]   prod     = pos_dir * res_reg;
  wire [23:0]         target   = prod[37:14];         // Four edges per pulse
  wire [15:0]         turn_rel = pos_dir[15:0] - zoff_reg;
  wire [15+RES_W:0]   zprod    = turn_rel * res_reg;
  wire                z_cell   = (zprod[15+RES_W:16] == {RES_W{1'b0}});

  // ****************************************
  // Incremental emulation
  // ****************************************
  reg  [23:0] inc_cnt_reg;
  reg  [3:0]  gap_reg;
  reg         qa_reg;
  reg         qb_reg;
  reg         zp_reg;
  wire [23:0] diff   = target - inc_cnt_reg;
  wire        inc_on = (emu_mode == `EES_MODE_INC);

  // Step one edge at a time, spaced so the port rate stays in limit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_cnt_reg <= 24'h000000;
      gap_reg     <= 4'h0;
      qa_reg      <= 1'b0;
      qb_reg      <= 1'b0;
      zp_reg      <= 1'b0;
    end else begin
      if (!inc_on) begin
        inc_cnt_reg <= target;                        // No burst when the mode turns on
        gap_reg     <= 4'h0;
      end else if (gap_reg < EDGE_CYC - 4'h1) begin
        gap_reg <= gap_reg + 4'h1;
      end else if (diff != 24'h000000) begin
        inc_cnt_reg <= diff[23] ? inc_cnt_reg - 24'h000001 : inc_cnt_reg + 24'h000001;
        gap_reg     <= 4'h0;
      end
      // Outputs registered so one driver feeds many slaves glitch-free
      qa_reg <= inc_on & inc_cnt_reg[1];
      qb_reg <= inc_on & (inc_cnt_reg[1] ^ inc_cnt_reg[0]);
      zp_reg <= inc_on & z_cell & (inc_cnt_reg[1:0] == 2'h2);
    end
  end

  assign quad_a     = qa_reg;
  assign quad_b     = qb_reg;
  assign zero_pulse = zp_reg;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  wire [1:0] pin_s;
  ees_sync #(
    .W (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({fb_data_pin, emu_clk_pin}),
    .q     (pin_s)
  );

  // ****************************************
  // Serial emulation
  // ****************************************
  reg  [1:0]  est_reg;
  reg         flt_reg;
  reg  [3:0]  stab_reg;
  reg  [7:0]  etmo_reg;
  reg  [31:0] sh_reg;
  reg  [5:0]  left_reg;
  reg         ed_reg;
  wire        accept = (pin_s[0] != flt_reg) && (stab_reg >= match_cyc);
  wire        fall   = accept & ~pin_s[0];
  wire        rise   = accept & pin_s[0];
  wire [31:0] word   = pos_dir << (5'h10 - rev_bits);
  wire [31:0] word_g = word ^ (word >> 1);

  assign emu_busy = (est_reg != E_IDLE);

  // Deglitch sized to the evaluator clock, then frame sequencing
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_reg  <= E_IDLE;
      flt_reg  <= 1'b1;
      stab_reg <= 4'h0;
      etmo_reg <= 8'h00;
      sh_reg   <= 32'h00000000;
      left_reg <= 6'h00;
      ed_reg   <= 1'b1;
    end else begin
      if (pin_s[0] == flt_reg)
        stab_reg <= 4'h0;
      else if (accept) begin
        flt_reg  <= pin_s[0];
        stab_reg <= 4'h0;
      end else
        stab_reg <= stab_reg + 4'h1;
      if (accept)
        etmo_reg <= 8'h00;
      else if (etmo_reg != 8'hFF)
        etmo_reg <= etmo_reg + 8'h01;
      case (est_reg)
        E_IDLE: begin
          ed_reg <= 1'b1;
          if (fall && emu_mode == `EES_MODE_SER) begin
            sh_reg   <= ctrl_reg[`EES_CTRL_EMU_GRAY] ? word_g : word;
            left_reg <= nbits;
            est_reg  <= E_SHIFT;
          end
        end
        E_SHIFT: begin
          if (rise && left_reg == 6'h00) begin
            ed_reg  <= 1'b0;
            est_reg <= E_TAIL;
          end else if (rise) begin
            ed_reg   <= sh_reg[31];
            sh_reg   <= {sh_reg[30:0], 1'b0};
            left_reg <= left_reg - 6'h01;
          end else if (etmo_reg >= tout_cyc - 8'h01) begin
            est_reg <= E_IDLE;
          end
        end
        E_TAIL: begin
          // Evaluator must leave the clock idle this long before the next frame
          if (etmo_reg >= tout_cyc - 8'h01) begin
            est_reg <= E_IDLE;
            ed_reg  <= 1'b1;
          end
        end
        default: est_reg <= E_IDLE;
      endcase
    end
  end

  assign emu_data = ed_reg;

  // ****************************************
  // Serial feedback reader
  // ****************************************
  reg  [1:0]  rst_reg;
  reg  [7:0]  rcnt_reg;
  reg  [5:0]  rbits_reg;
  reg  [31:0] acc_reg;
  reg         fbc_reg;
  wire        rdr_en = (gear_mode == `EES_GEAR_SER) || (fb_type == `EES_FBT_SER);
  wire        half_done = (rcnt_reg >= half_cyc - 8'h01);

  assign rdr_busy = (rst_reg != R_GAP);
  assign fb_clk   = fbc_reg;

  // Clock half period never below the port rate limit; sample on falling edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_reg   <= R_GAP;
      rcnt_reg  <= 8'h00;
      rbits_reg <= 6'h00;
      acc_reg   <= 32'h00000000;
      fbc_reg   <= 1'b1;
      fbpos_reg <= 32'h00000000;
    end else begin
      rcnt_reg <= (rcnt_reg == 8'hFF) ? rcnt_reg : rcnt_reg + 8'h01;
      case (rst_reg)
        R_GAP: begin
          fbc_reg <= 1'b1;
          if (rdr_en && rcnt_reg >= tout_cyc) begin
            rst_reg   <= R_LOW;
            rcnt_reg  <= 8'h00;
            rbits_reg <= nbits;
            acc_reg   <= 32'h00000000;
            fbc_reg   <= 1'b0;
          end
        end
        R_LOW: begin
          if (half_done) begin
            rst_reg  <= R_HIGH;
            rcnt_reg <= 8'h00;
            fbc_reg  <= 1'b1;
          end
        end
        R_HIGH: begin
          if (half_done && rbits_reg == 6'h00) begin
            rst_reg   <= R_GAP;
            rcnt_reg  <= 8'h00;
            fbpos_reg <= ctrl_reg[`EES_CTRL_FB_GRAY] ? gray2bin(acc_reg) : acc_reg;
          end else if (half_done) begin
            rst_reg   <= R_LOW;
            rcnt_reg  <= 8'h00;
            fbc_reg   <= 1'b0;
            acc_reg   <= {acc_reg[30:0], pin_s[1]};
            rbits_reg <= rbits_reg - 6'h01;
          end
        end
        default: rst_reg <= R_GAP;
      endcase
    end
  end
endmodule

/* File: logic/ees_regs.vh */
`ifndef EES_REGS_VH
`define EES_REGS_VH
// ****************************************
// Register byte offsets
// ****************************************
`define EES_ADDR_CTRL        8'h00
`define EES_ADDR_RES         8'h04
`define EES_ADDR_ZOFF        8'h08
`define EES_ADDR_CLK         8'h0C
`define EES_ADDR_STAT        8'h10
`define EES_ADDR_FBPOS       8'h14
// ****************************************
// Control and clock register field positions
// ****************************************
`define EES_CTRL_MODE_LSB    0
`define EES_CTRL_GEAR_LSB    4
`define EES_CTRL_EMU_GRAY    8
`define EES_CTRL_FB_GRAY     9
`define EES_CTRL_TOUT_SEL    10
`define EES_CTRL_DIR_INV     11
`define EES_CTRL_SAFETY      12
`define EES_CTRL_REVB_LSB    16
`define EES_CTRL_FBT_LSB     24
`define EES_CLK_MATCH_LSB    8
// ****************************************
// Reset values
// ****************************************
`define EES_CTRL_RESET       32'h000C0000
`define EES_RES_RESET        20'h00400
`define EES_ZOFF_RESET       16'h0000
`define EES_CLK_RESET        12'h108
// ****************************************
// Mode codes
// ****************************************
`define EES_MODE_INC         3'h1
`define EES_MODE_SER         3'h2
`define EES_GEAR_SER         3'h5
`define EES_FBT_RESOLVER     6'h00
`define EES_FBT_SER          6'h09
// ****************************************
// Resolution limits and frame widths
// ****************************************
`define EES_RES_RSLV_MIN     20'h00020
`define EES_RES_RSLV_MAX     20'h01000
`define EES_RES_ENC_MIN      20'h00100
`define EES_RES_ENC_MAX      20'h80000
`define EES_RES_SAFE_MAX     20'h01000
`define EES_REVB_MIN         5'h0C
`define EES_REVB_MAX         5'h10
`define EES_TURN_BITS        6'h10
// ****************************************
// Timing
// ****************************************
`define EES_CLK_MHZ          10
`define EES_CLK_HZ           10000000
`define EES_TOUT_SHORT_NS    3000
`define EES_TOUT_LONG_NS     13000
`define EES_EDGE_SPACING_NS  200
`define EES_MAX_RATE_HZ      1500000
// Cycle counts at the 10 MHz clock, sized to the counters that use them
`define EES_TOUT_SHORT_CYC   8'h1E
`define EES_TOUT_LONG_CYC    8'h82
`define EES_EDGE_CYC         4'h2
`define EES_HALF_MIN_CYC     8'h04
`endif

/* File: logic/ees_sync.v */
`timescale 1ns/1ps
// ****************************************
// Two-flop synchroniser
// ****************************************
module ees_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule

/* File: dv/ees_checker.sv */
`timescale 1ns/1ps
module ees_checker (
  input logic        pclk,
  input logic        presetn,
  input logic [7:0]  paddr,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  input logic [15:0] shaft_turn,
  input logic [15:0] shaft_rev,
  input logic        emu_clk_pin,
  input logic        emu_data,
  input logic        quad_a,
  input logic        quad_b,
  input logic        zero_pulse,
  input logic        fb_clk,
  input logic        fb_data_pin
);
  // ****************************************
  // Helper state
  // ****************************************
  logic [2:0] mode_q;
  logic [1:0] mode_age;
  logic [7:0] hi_cnt;
  logic [3:0] lo_cnt;
  wire        ctrl_wr = psel && penable && pwrite && paddr == 8'h00;
  wire        mapped  = paddr[1:0] == 2'h0 && paddr <= 8'h14;

  // Mode copy and its age; outputs may lag a mode change, so checks wait it out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q   <= 3'h0;
      mode_age <= 2'h0;
      hi_cnt   <= 8'h00;
      lo_cnt   <= 4'h0;
    end else begin
      mode_q   <= ctrl_wr ? pwdata[2:0] : mode_q;
      mode_age <= (ctrl_wr && pwdata[2:0] != mode_q) ? 2'h0 : (mode_age == 2'h3 ? mode_age : mode_age + 2'h1);
      hi_cnt   <= !emu_clk_pin ? 8'h00 : (hi_cnt == 8'hFF ? hi_cnt : hi_cnt + 8'h01);
      lo_cnt   <= emu_clk_pin ? 4'h0 : (lo_cnt == 4'hF ? lo_cnt : lo_cnt + 4'h1);
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence fb_hold;
    $stable(fb_clk) [*3];
  endsequence
  sequence quad_quiet;
    $stable(quad_a) && $stable(quad_b);
  endsequence

  zero_at_ab_a: assert property (zero_pulse |-> quad_a && quad_b)
    else $error("zero pulse outside A and B high");
  quad_single_a: assert property (mode_age == 2'h3 && mode_q == 3'h1 |-> !($changed(quad_a) && $changed(quad_b)))
    else $error("A and B changed together");
  quad_spacing_a: assert property (mode_age == 2'h3 && mode_q == 3'h1 && ($changed(quad_a) || $changed(quad_b))
    |=> quad_quiet)
    else $error("quadrature edges too close");
  quad_off_a: assert property (mode_age == 2'h3 && mode_q != 3'h1 |-> !quad_a && !quad_b && !zero_pulse)
    else $error("incremental outputs active outside mode 1");
  emu_idle_a: assert property (hi_cnt >= 8'hA0 |-> emu_data)
    else $error("serial data not idle high after timeout");
  emu_steady_a: assert property (lo_cnt >= 4'h8 |-> $stable(emu_data))
    else $error("serial data moved while clock held low");
  fb_rate_a: assert property ($changed(fb_clk) |=> fb_hold)
    else $error("reader clock half period too short");
  err_map_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("slave error does not match address map");
  err_zero_a: assert property (psel && penable && !pwrite && pslverr |-> prdata == 32'h0)
    else $error("unmapped read returned data");
endmodule

bind ees_top ees_checker u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .shaft_turn(shaft_turn), .shaft_rev(shaft_rev), .emu_clk_pin(emu_clk_pin), .emu_data(emu_data),
  .quad_a(quad_a), .quad_b(quad_b), .zero_pulse(zero_pulse), .fb_clk(fb_clk), .fb_data_pin(fb_data_pin)
);

/* File: dv/ees_far_end.sv */
`timescale 1ns/1ps
module ees_far_end (
  input  logic        pclk,
  input  logic        emu_data,
  output logic        emu_clk,
  input  logic        fb_clk,
  input  logic [31:0] fb_word,
  output logic        fb_data
);
  logic        fb_prev = 1'b1;
  logic [4:0]  fb_high = 5'h00;
  logic [31:0] sr      = 32'h0;
  initial emu_clk = 1'b1;
  initial fb_data = 1'b1;

  // Encoder: load at the first fall after a gap, shift on each rise; noise in the gap
  always @(posedge pclk) begin
    fb_prev <= fb_clk;
    fb_high <= !fb_clk ? 5'h00 : (fb_high == 5'h1F ? fb_high : fb_high + 5'h01);
    if (fb_prev && !fb_clk && fb_high >= 5'h14) begin
      sr <= fb_word;
    end else if (!fb_prev && fb_clk) begin
      fb_data <= sr[31];
      sr      <= {sr[30:0], 1'b0};
    end else if (fb_high >= 5'h14) begin
      fb_data <= ~fb_data;
    end
  end

  // Evaluator at 800 ns period; each bit is taken just before the next rise
  task automatic read_frame(input int nb, output logic [31:0] w);
    w = 32'h0;
    emu_clk <= 1'b0;
    repeat (12) @(posedge pclk);
    for (int i = 0; i <= nb; i++) begin
      if (i > 0) w = {w[30:0], emu_data};
      emu_clk <= 1'b1;
      repeat (4) @(posedge pclk);
      if (i < nb) begin
        emu_clk <= 1'b0;
        repeat (4) @(posedge pclk);
      end
    end
    // Clock is left high; the caller keeps it idle past the timeout
  endtask
endmodule

/* File: dv/ees_top_bench.sv */
`timescale 1ns/1ps
`include "ees_regs.vh"
module ees_top_bench;
  // ****************************************
  // Stimulus and wiring
  // ****************************************
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] shaft_turn = 16'h0;
  logic [15:0] shaft_rev = 16'h0;
  logic [31:0] fb_word = 32'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, emu_clk_pin, emu_data, quad_a, quad_b, zero_pulse, fb_clk, fb_data_pin;
  int          n_fail = 0;
  int          checks_done = 0;
  int          qpos = 0;
  logic [1:0]  qprev = 2'h0;
  wire  [1:0]  qc = {quad_a, quad_a ^ quad_b};

  always #50 pclk = ~pclk;

  ees_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shaft_turn(shaft_turn), .shaft_rev(shaft_rev), .emu_clk_pin(emu_clk_pin), .emu_data(emu_data),
    .quad_a(quad_a), .quad_b(quad_b), .zero_pulse(zero_pulse), .fb_clk(fb_clk), .fb_data_pin(fb_data_pin));
  ees_far_end u_far (.pclk(pclk), .emu_data(emu_data), .emu_clk(emu_clk_pin), .fb_clk(fb_clk),
    .fb_word(fb_word), .fb_data(fb_data_pin));

  // Quadrature counter; a two-step jump is left to the checker
  always @(posedge pclk) begin
    if (qc - qprev == 2'h1) qpos <= qpos + 1;
    else if (qprev - qc == 2'h1) qpos <= qpos - 1;
    qprev <= qc;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One APB transfer, then an idle cycle so calls never collide
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      end_of_test();
    end
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb(1'b1, a, d, q, er);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    logic        er;
    apb(1'b0, a, 32'h0, q, er);
    check(nm, e, q);
  endtask

  task automatic wait_q(input int e);
    int k;
    k = 0;
    while (qpos != e && k < 300) begin
      @(posedge pclk);
      k++;
    end
    check("quad count", e, qpos);
    if (qpos != e)
      end_of_test();
  endtask

  task automatic wait_busy(input logic v);
    logic [31:0] q;
    logic        er;
    int          k;
    k = 0;
    do begin
      apb(1'b0, `EES_ADDR_STAT, 32'h0, q, er);
      k++;
    end while (q[2] !== v && k < 600);
    if (q[2] !== v) begin
      n_fail++;
      end_of_test();
    end
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (100000) @(posedge pclk);
    n_fail++;
    end_of_test();
  end

  initial begin
    logic [31:0] q, w, pos;
    logic        er;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset values and an unmapped slot
    rdc("ctrl", `EES_ADDR_CTRL, `EES_CTRL_RESET);
    rdc("res", `EES_ADDR_RES, 32'h400);
    rdc("zoff", `EES_ADDR_ZOFF, 32'h0);
    rdc("clk", `EES_ADDR_CLK, 32'h108);
    rdc("stat", `EES_ADDR_STAT, 32'h0);
    rdc("fbpos", `EES_ADDR_FBPOS, 32'h0);
    apb(1'b0, 8'h18, 32'h0, q, er);
    check("unmapped err", 32'h1, er);
    check("unmapped data", 32'h0, q);
    // Resolution range ends, then safety card powers of two
    wr(`EES_ADDR_RES, 32'h1001);
    rdc("res high", `EES_ADDR_RES, 32'h400);
    rdc("refused", `EES_ADDR_STAT, 32'h2);
    wr(`EES_ADDR_STAT, 32'h2);
    wr(`EES_ADDR_RES, 32'h20);
    rdc("res low", `EES_ADDR_RES, 32'h20);
    wr(`EES_ADDR_CTRL, 32'h000C1000);
    wr(`EES_ADDR_RES, 32'h300);
    rdc("res safe", `EES_ADDR_RES, 32'h20);
    wr(`EES_ADDR_RES, 32'h1000);
    rdc("res pow2", `EES_ADDR_RES, 32'h1000);
    wr(`EES_ADDR_STAT, 32'h2);
    rdc("cleared", `EES_ADDR_STAT, 32'h0);
    // Encoder feedback range: top end taken, a resolver-only value refused
    wr(`EES_ADDR_CTRL, 32'h010C0000);
    wr(`EES_ADDR_RES, 32'h00080000);
    rdc("res enc", `EES_ADDR_RES, 32'h00080000);
    wr(`EES_ADDR_RES, 32'h000000FF);
    rdc("res enc low", `EES_ADDR_RES, 32'h00080000);
    wr(`EES_ADDR_STAT, 32'h2);
    // Incremental output: count direction, zero pulse cell and its offset
    wr(`EES_ADDR_RES, 32'h400);
    wr(`EES_ADDR_CTRL, 32'h000C0001);
    shaft_turn <= 16'h0020;
    wait_q(2);
    repeat (3) @(posedge pclk);
    check("zero pulse", 32'h1, zero_pulse);
    wr(`EES_ADDR_ZOFF, 32'h1000);
    repeat (3) @(posedge pclk);
    check("zero offset", 32'h0, zero_pulse);
    shaft_turn <= 16'h0100;
    wait_q(16);
    wr(`EES_ADDR_RES, 32'h800);
    wait_q(32);
    // Serial frame, 12 revolution bits, input moved after the first fall
    wr(`EES_ADDR_CTRL, 32'h000C0002);
    shaft_rev  <= 16'hCABC;
    shaft_turn <= 16'h1234;
    @(posedge pclk);
    fork
      u_far.read_frame(28, w);
      begin
        repeat (20) @(posedge pclk);
        shaft_turn <= 16'h8421;
      end
    join
    check("frame binary", 32'h0ABC1234, w);
    repeat (4) @(posedge pclk);
    check("frame tail", 32'h0, emu_data);
    repeat (40) @(posedge pclk);
    check("idle short", 32'h1, emu_data);
    // Full 32-bit Gray frame, long timeout, inverted direction, slower deglitch
    wr(`EES_ADDR_CLK, 32'h00000308);
    wr(`EES_ADDR_CTRL, 32'h00100D02);
    repeat (150) @(posedge pclk);
    pos = 32'h00000000 - {16'hCABC, 16'h8421};
    u_far.read_frame(32, w);
    check("frame gray", pos ^ (pos >> 1), w);
    repeat (64) @(posedge pclk);
    check("hold long", 32'h0, emu_data);
    repeat (100) @(posedge pclk);
    check("idle long", 32'h1, emu_data);
    // Feedback reader in gearing mode 5 with Gray, then as serial feedback type in binary
    fb_word <= {28'h9A5C3E1 ^ (28'h9A5C3E1 >> 1), 4'h0};
    wr(`EES_ADDR_CTRL, 32'h000C0250);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdc("fb gray", `EES_ADDR_FBPOS, 32'h09A5C3E1);
    fb_word <= {28'h123ABCD, 4'h0};
    wr(`EES_ADDR_CTRL, 32'h090C0000);
    wait_busy(1'b0);
    wait_busy(1'b1);
    wait_busy(1'b0);
    rdc("fb binary", `EES_ADDR_FBPOS, 32'h0123ABCD);
    end_of_test();
  end
endmodule
